// *** include/arith_pkg.sv ***
// Purpose: shared constants for the accumulator arithmetic/compare unit
// Assumes: 18-bit one's-complement words, 25 MHz system clock
// Notes: opcodes are six-bit function codes written in hex
package arith_pkg;
  // word layout
  localparam int WORD_W = 18;
  localparam int ADDR_W = 16;
  localparam int SIGN_BIT = 17;
  localparam logic [17:0] ALL_ONES = 18'h3FFFF;
  localparam logic [17:0] ZERO_WORD = 18'h00000;

  // function codes handled here (even codes; bit 0 selects indexing)
  localparam logic [5:0] OP_COMPARE_LOWER = 6'h02;
  localparam logic [5:0] OP_MASKED_SUBSTITUTE = 6'h04;
  localparam logic [5:0] OP_COMPARE_MASKED = 6'h06;
  localparam logic [5:0] OP_LOAD_UPPER = 6'h08;
  localparam logic [5:0] OP_LOAD_LOWER = 6'h0A;
  localparam logic [5:0] OP_ADD_LOWER = 6'h0C;
  localparam logic [5:0] OP_SUB_LOWER = 6'h0E;
  localparam logic [5:0] OP_ADD_DOUBLE = 6'h10;
  localparam logic [5:0] OP_SUB_DOUBLE = 6'h12;
  localparam logic [5:0] OP_MULTIPLY_LOWER = 6'h14;
  localparam logic [5:0] OP_FIRST = 6'h02;
  localparam logic [5:0] OP_LAST = 6'h15;

  // format II skips that clear overflow, and the compare-keeping group
  localparam logic [5:0] OP_FORMAT2 = 6'h28;
  localparam logic [5:0] MINOR_SKIP_OVF = 6'h2A;
  localparam logic [5:0] MINOR_SKIP_NO_OVF = 6'h2B;
  localparam logic [2:0] KEEP_GROUP = 3'h6;

  // bank select register layout
  localparam int BANK_ACTIVE_BIT = 3;
  localparam int BANK_HIGH_BIT = 4;

  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SINGLE_TIME_US = 4;
  localparam int DOUBLE_TIME_US = 6;
  localparam int MULTIPLY_TIME_US = 14;
  localparam int SINGLE_CYCLES = SINGLE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int DOUBLE_CYCLES = DOUBLE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int MULTIPLY_CYCLES = MULTIPLY_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int CNT_W = 9;

  // software register map
  localparam int RADDR_W = 4;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h1;
  localparam logic [3:0] REG_UPPER = 4'h2;
  localparam logic [3:0] REG_LOWER = 4'h3;
  localparam logic [3:0] REG_FLAGS = 4'h4;
  localparam int STAT_W = 3;
  localparam int ST_DONE = 0;
  localparam int ST_OVF = 1;
  localparam int ST_BORROW = 2;
  localparam logic [2:0] MASK_RESET = 3'h0;
endpackage

// *** include/alu_if.sv ***
// Purpose: operand and result carrier between control and arithmetic
// Assumes: single clock domain, purely combinational consumers
// Notes: subtraction is done by the controller complementing opB
`timescale 1ns/10ps
`default_nettype none
interface alu_if;
  logic [17:0] opA;
  logic [17:0] opB;
  logic [17:0] sum;
  logic ovf;
  logic [35:0] prod;
  modport ctrl(output opA, output opB, input sum, input ovf, input prod);
  modport adder(input opA, input opB, output sum, output ovf);
  modport mult(input opA, input opB, output prod);
endinterface
`default_nettype wire

// *** design/ones_adder.sv ***
// Purpose: 18-bit one's-complement adder with end-around carry
// Assumes: operands arrive already complemented for subtraction
// Notes: combinational; overflow from like signs giving other sign
`timescale 1ns/10ps
`default_nettype none
module ones_adder (
  // operand and result carrier
  alu_if.adder alu
);
  logic [18:0] raw;
  logic [18:0] wrapped;

  // end-around carry folds the carry back in so -0 + x stays correct
  always_comb begin
    raw = {1'b0, alu.opA} + {1'b0, alu.opB};
    wrapped = {1'b0, raw[17:0]} + {18'h00000, raw[18]};
    alu.sum = wrapped[17:0];
    alu.ovf = (alu.opA[17] == alu.opB[17]) &&
              (wrapped[17] != alu.opA[17]);
  end
endmodule
`default_nettype wire

// *** design/sign_mag_multiplier.sv ***
// Purpose: one's-complement multiply through magnitudes
// Assumes: 18-bit factors, product fills the 36-bit pair
// Notes: combinational; the controller waits out the documented time
`timescale 1ns/10ps
`default_nettype none
module sign_mag_multiplier (
  // operand and result carrier
  alu_if.mult alu
);
  logic [16:0] magA;
  logic [16:0] magB;
  logic [33:0] magProd;
  logic [35:0] wide;

  // absolute values, unsigned product, then sign correction
  always_comb begin
    magA = alu.opA[17] ? ~alu.opA[16:0] : alu.opA[16:0];
    magB = alu.opB[17] ? ~alu.opB[16:0] : alu.opB[16:0];
    magProd = magA * magB;
    wide = {2'h0, magProd};
    alu.prod = (alu.opA[17] ^ alu.opB[17]) ? ~wide : wide;
  end
endmodule
`default_nettype wire

// *** design/accumulator_arith_compare_unit.sv ***
// Purpose: arithmetic, compare, substitute, load and multiply datapath
// Assumes: memory answers a read with memValid on a later clock
// Notes: start begins an instruction only while idle, but its designator clears work in any state; bus writes to the
//   accumulators are ignored while an instruction is in flight
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module accumulator_arith_compare_unit (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // instruction control
  input wire logic start,
  input wire logic [5:0] opcode,
  input wire logic [5:0] minorCode,
  input wire logic [11:0] addrField,
  input wire logic [17:0] indexReg,
  input wire logic [3:0] progBank,
  input wire logic [4:0] bankSel,
  output logic busy,
  output logic done,
  output logic intHold,
  // core memory read port
  output logic memReq,
  output logic [15:0] memAddr,
  input wire logic memValid,
  input wire logic [17:0] memData,
  // accumulators and designators
  output logic [17:0] upperAcc,
  output logic [17:0] lowerAcc,
  output logic [4:0] flags,
  // software register port
  input wire logic [3:0] regAddr,
  input wire logic [17:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [17:0] regRdata,
  output logic irq
);
  typedef enum logic [1:0] {IDLE, WAIT_MEM, EXEC} state_type;

  state_type state_r;
  logic [5:0] op_r;
  logic hiPhase_r;
  logic [15:0] addr_r;
  logic [17:0] opLo_r;
  logic [17:0] opHi_r;
  logic [8:0] cnt_r;
  logic [8:0] target_r;
  logic memReq_r;
  logic [15:0] memAddr_r;
  logic busy_r;
  logic done_r;
  logic [17:0] upperAcc_r;
  logic [17:0] lowerAcc_r;
  logic compare_r;
  logic greater_r;
  logic equals_r;
  logic overflow_r;
  logic borrow_r;
  logic [2:0] status_r;
  logic [2:0] mask_r;
  logic [17:0] regRdata_r;
  logic irq_r;

  logic takeStart;
  logic applyNow;
  logic isDouble;
  logic isCompare;
  logic [3:0] bank;
  logic [15:0] baseAddr;
  logic [15:0] effAddr;
  logic [17:0] cmpA;
  logic [17:0] cmpB;
  logic [35:0] dOperand;
  logic [36:0] dSum;
  logic dOvf;
  logic ovfEvent;
  logic skipClear;
  logic [2:0] events;

  alu_if alu ();

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // one's-complement word to a signed integer; -0 and +0 map to 0
  function automatic logic signed [18:0] toInt(input logic [17:0] w);
    logic [18:0] mag;
    mag = w[17] ? {2'h0, ~w[16:0]} : {2'h0, w[16:0]};
    return w[17] ? -$signed(mag) : $signed(mag);
  endfunction

  // execution time of an even function code, in cycles minus one
  function automatic logic [8:0] latency(input logic [5:0] op);
    logic [8:0] lat;
    lat = 9'(arith_pkg::SINGLE_CYCLES - 1);
    if (op == arith_pkg::OP_ADD_DOUBLE || op == arith_pkg::OP_SUB_DOUBLE)
      lat = 9'(arith_pkg::DOUBLE_CYCLES - 1);
    if (op == arith_pkg::OP_MULTIPLY_LOWER)
      lat = 9'(arith_pkg::MULTIPLY_CYCLES - 1);
    return lat;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decode and operand address

  always_comb begin
    takeStart = start && (state_r == IDLE) &&
                (opcode >= arith_pkg::OP_FIRST) &&
                (opcode <= arith_pkg::OP_LAST);
    applyNow = (state_r == EXEC) && (cnt_r >= target_r);
    isDouble = (op_r == arith_pkg::OP_ADD_DOUBLE) ||
               (op_r == arith_pkg::OP_SUB_DOUBLE);
    isCompare = (op_r == arith_pkg::OP_COMPARE_LOWER) ||
                (op_r == arith_pkg::OP_COMPARE_MASKED);
    skipClear = start && (opcode == arith_pkg::OP_FORMAT2) &&
                ((minorCode == arith_pkg::MINOR_SKIP_OVF) ||
                 (minorCode == arith_pkg::MINOR_SKIP_NO_OVF));
    // bank bits of the select register are split around its flag
    bank = bankSel[arith_pkg::BANK_ACTIVE_BIT] ?
           {bankSel[arith_pkg::BANK_HIGH_BIT], bankSel[2:0]} :
           progBank;
    baseAddr = {bank, addrField};
    effAddr = opcode[0] ? baseAddr + indexReg[15:0] : baseAddr;
  end

  ////////////////////////////////////////////////////////////////////////
  // arithmetic operand steering

  always_comb begin
    alu.opA = lowerAcc_r;
    alu.opB = (op_r == arith_pkg::OP_SUB_LOWER) ? ~opLo_r : opLo_r;
    // linked pair subtracts: add is A minus the complement, hence the +1;
    // no carry-out means a blocked end-around borrow, left uncorrected
    dOperand = (op_r == arith_pkg::OP_SUB_DOUBLE) ?
               ~{opHi_r, opLo_r} : {opHi_r, opLo_r};
    dSum = {1'b0, upperAcc_r, lowerAcc_r} + {1'b0, dOperand} +
           37'h0000000001;
    dOvf = (upperAcc_r[17] == dOperand[35]) &&
           (dSum[35] != upperAcc_r[17]);
    cmpA = (op_r == arith_pkg::OP_COMPARE_MASKED) ?
           (lowerAcc_r & upperAcc_r) : lowerAcc_r;
    cmpB = (op_r == arith_pkg::OP_COMPARE_MASKED) ?
           (opLo_r & upperAcc_r) : opLo_r;
    ovfEvent = applyNow && ((((op_r == arith_pkg::OP_ADD_LOWER) ||
               (op_r == arith_pkg::OP_SUB_LOWER)) && alu.ovf) ||
               (isDouble && dOvf));
    events = '0;
    events[arith_pkg::ST_DONE] = applyNow;
    events[arith_pkg::ST_OVF] = ovfEvent;
    events[arith_pkg::ST_BORROW] = applyNow && isDouble && !dSum[36];
  end

  ones_adder adder (.alu(alu));
  sign_mag_multiplier mult (.alu(alu));

  ////////////////////////////////////////////////////////////////////////
  // sequencing and operand fetch

  // a double word asks for the addressed cell first, then the one after it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r <= IDLE;
      op_r <= 6'h00;
      hiPhase_r <= 1'b0;
      addr_r <= 16'h0000;
      opLo_r <= 18'h00000;
      opHi_r <= 18'h00000;
      memReq_r <= 1'b0;
      memAddr_r <= 16'h0000;
      target_r <= 9'h000;
    end else begin
      memReq_r <= 1'b0;
      case (state_r)
        IDLE: begin
          if (takeStart) begin
            op_r <= {opcode[5:1], 1'b0};
            target_r <= latency({opcode[5:1], 1'b0});
            addr_r <= effAddr;
            hiPhase_r <= 1'b0;
            memReq_r <= 1'b1;
            memAddr_r <= effAddr;
            state_r <= WAIT_MEM;
          end
        end
        WAIT_MEM: begin
          if (memValid) begin
            if (hiPhase_r) begin
              opHi_r <= memData;
              state_r <= EXEC;
            end else begin
              opLo_r <= memData;
              if (isDouble) begin
                hiPhase_r <= 1'b1;
                memReq_r <= 1'b1;
                memAddr_r <= addr_r + 16'h0001;
              end else begin
                state_r <= EXEC;
              end
            end
          end
        end
        EXEC: begin
          if (applyNow)
            state_r <= IDLE;
        end
        default: state_r <= IDLE;
      endcase
    end
  end

  // execution timer runs from the accepted start
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      cnt_r <= 9'h000;
    else if (takeStart)
      cnt_r <= 9'h000;
    else if (busy_r && cnt_r != 9'h1FF)
      cnt_r <= cnt_r + 9'h001;
  end

  // busy and completion pulse
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= applyNow;
      if (takeStart)
        busy_r <= 1'b1;
      else if (applyNow)
        busy_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // accumulators

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      upperAcc_r <= 18'h00000;
      lowerAcc_r <= 18'h00000;
    end else if (applyNow) begin
      case (op_r)
        arith_pkg::OP_MASKED_SUBSTITUTE:
          lowerAcc_r <= (lowerAcc_r & ~upperAcc_r) |
                        (opLo_r & upperAcc_r);
        arith_pkg::OP_LOAD_UPPER: upperAcc_r <= opLo_r;
        arith_pkg::OP_LOAD_LOWER: lowerAcc_r <= opLo_r;
        arith_pkg::OP_ADD_LOWER: lowerAcc_r <= alu.sum;
        arith_pkg::OP_SUB_LOWER: lowerAcc_r <= alu.sum;
        arith_pkg::OP_ADD_DOUBLE: begin
          {upperAcc_r, lowerAcc_r} <= dSum[35:0];
        end
        arith_pkg::OP_SUB_DOUBLE: begin
          {upperAcc_r, lowerAcc_r} <= dSum[35:0];
        end
        arith_pkg::OP_MULTIPLY_LOWER: begin
          {upperAcc_r, lowerAcc_r} <= alu.prod;
        end
        default: begin
          upperAcc_r <= upperAcc_r; // compares keep both
        end
      endcase
    end else if (regWr && !busy_r) begin
      if (regAddr == arith_pkg::REG_UPPER)
        upperAcc_r <= regWdata;
      if (regAddr == arith_pkg::REG_LOWER)
        lowerAcc_r <= regWdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // designators

  // a result landing beats a clear arriving in the same cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      compare_r <= 1'b0;
      greater_r <= 1'b0;
      equals_r <= 1'b0;
    end else if (applyNow && isCompare) begin
      compare_r <= 1'b1;
      greater_r <= toInt(cmpA) > toInt(cmpB);
      equals_r <= toInt(cmpA) == toInt(cmpB);
    end else if (start && opcode[5:3] != arith_pkg::KEEP_GROUP) begin
      compare_r <= 1'b0;
      greater_r <= 1'b0;
      equals_r <= 1'b0;
    end
  end

  // overflow sticks; borrow is rewritten by every double op
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      overflow_r <= 1'b0;
      borrow_r <= 1'b0;
    end else begin
      if (ovfEvent)
        overflow_r <= 1'b1;
      else if (skipClear)
        overflow_r <= 1'b0;
      if (applyNow && isDouble)
        borrow_r <= !dSum[36];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register port and interrupt

  // status clears on read, but a same-cycle event still lands
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      status_r <= 3'h0;
      mask_r <= arith_pkg::MASK_RESET;
      regRdata_r <= 18'h00000;
      irq_r <= 1'b0;
    end else begin
      if (regRd && regAddr == arith_pkg::REG_STATUS)
        status_r <= events;
      else
        status_r <= status_r | events;
      if (regWr && regAddr == arith_pkg::REG_MASK)
        mask_r <= regWdata[2:0];
      irq_r <= |(status_r & mask_r);
      regRdata_r <= 18'h00000;
      if (regRd) begin
        case (regAddr)
          arith_pkg::REG_STATUS: regRdata_r <= {15'h0000, status_r};
          arith_pkg::REG_MASK: regRdata_r <= {15'h0000, mask_r};
          arith_pkg::REG_UPPER: regRdata_r <= upperAcc_r;
          arith_pkg::REG_LOWER: regRdata_r <= lowerAcc_r;
          arith_pkg::REG_FLAGS: regRdata_r <= {13'h0000, borrow_r,
            overflow_r, equals_r, greater_r, compare_r};
          default: regRdata_r <= 18'h00000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign busy = busy_r;
  assign done = done_r;
  assign intHold = compare_r;
  assign memReq = memReq_r;
  assign memAddr = memAddr_r;
  assign upperAcc = upperAcc_r;
  assign lowerAcc = lowerAcc_r;
  assign flags = {borrow_r, overflow_r, equals_r, greater_r, compare_r};
  assign regRdata = regRdata_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_cmp_clears: assert property (start && !applyNow &&
    opcode[5:3] != arith_pkg::KEEP_GROUP |=> !compare_r)
    else $error("compare designator not cleared");
  a_cmp_keeps: assert property (applyNow && isCompare
    |=> compare_r && $stable(lowerAcc_r) && $stable(upperAcc_r))
    else $error("compare changed an accumulator");
  a_subst_bits: assert property (applyNow &&
    op_r == arith_pkg::OP_MASKED_SUBSTITUTE |=> lowerAcc_r ==
    (($past(lowerAcc_r) & ~$past(upperAcc_r)) |
     ($past(opLo_r) & $past(upperAcc_r))) && $stable(upperAcc_r))
    else $error("substitute result wrong");
  a_load_upper: assert property (applyNow &&
    op_r == arith_pkg::OP_LOAD_UPPER |=> upperAcc_r == $past(opLo_r))
    else $error("upper load wrong");
  a_all_ones: assert property (applyNow &&
    op_r == arith_pkg::OP_SUB_LOWER && lowerAcc_r == arith_pkg::ALL_ONES
    && opLo_r == arith_pkg::ZERO_WORD |=> lowerAcc_r == arith_pkg::ALL_ONES)
    else $error("all-ones subtract wrong");
  a_ovf_sticky: assert property (overflow_r && !skipClear
    |=> overflow_r)
    else $error("overflow dropped without skip");
  a_borrow_src: assert property ($changed(borrow_r)
    |-> $past(applyNow && isDouble))
    else $error("borrow changed outside double op");
  a_mul_place: assert property (applyNow &&
    op_r == arith_pkg::OP_MULTIPLY_LOWER
    |=> {upperAcc_r, lowerAcc_r} == $past(alu.prod))
    else $error("product not placed in pair");
  a_done_time: assert property (takeStart
    |-> !done_r ##1 (!done_r)[*8])
    else $error("instruction finished too early");

  c_double_add: cover property (applyNow &&
    op_r == arith_pkg::OP_ADD_DOUBLE && !dSum[36]);
  c_masked_cmp: cover property (applyNow &&
    op_r == arith_pkg::OP_COMPARE_MASKED ##1 greater_r);
  c_ovf_clear: cover property (overflow_r ##1 skipClear ##1 !overflow_r);
endmodule
`default_nettype wire

// *** bench/core_mem_model.sv ***
// Purpose: core memory read partner for the arithmetic unit
// Assumes: one read in flight at a time
// Notes: answer delay is set by the bench through lat
`timescale 1ns/10ps
`default_nettype none
module core_mem_model (
  // clock
  input wire logic clock,
  // read port
  input wire logic memReq,
  input wire logic [15:0] memAddr,
  output logic memValid = 1'b0,
  output logic [17:0] memData = 18'h00000
);
  logic [17:0] mem [0:65535];
  logic [15:0] holdAddr_r = 16'h0000;
  int waitCnt_r = 0;
  int lat = 1;

  // answer lat cycles after the request; idle data toggles so no stale
  // word can be mistaken for an answer
  always @(posedge clock) begin
    memValid <= 1'b0;
    if (memReq) begin
      holdAddr_r <= memAddr;
      waitCnt_r <= lat;
    end else if (waitCnt_r > 1) begin
      waitCnt_r <= waitCnt_r - 1;
    end else if (waitCnt_r == 1) begin
      waitCnt_r <= 0;
      memValid <= 1'b1;
      memData <= mem[holdAddr_r];
    end else begin
      memData <= ~memData;
    end
  end
endmodule
`default_nettype wire

// *** bench/accumulator_arith_compare_unit_tb.sv ***
// Purpose: self-checking bench for the accumulator arithmetic unit
// Assumes: accumulators preset over the register port
// Notes: outputs are read at the edge, before that edge's updates
`timescale 1ns/10ps
`default_nettype none
module accumulator_arith_compare_unit_tb;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0;
  logic [5:0] opcode = 6'h00;
  logic [5:0] minorCode = 6'h00;
  logic [11:0] addrField = 12'h000;
  logic [17:0] indexReg = 18'h00000;
  logic [3:0] progBank = 4'h0;
  logic [4:0] bankSel = 5'h00;
  logic [3:0] regAddr = 4'h0;
  logic [17:0] regWdata = 18'h00000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic busy, done, intHold, memReq, memValid, irq;
  logic [15:0] memAddr;
  logic [17:0] memData, upperAcc, lowerAcc, regRdata, rv;
  logic [4:0] flags;
  int n_fail = 0;
  int n_tests = 0;
  int cyc;

  always #20 clock = ~clock;

  accumulator_arith_compare_unit i_dut (.clock, .nrst, .start, .opcode,
    .minorCode, .addrField, .indexReg, .progBank, .bankSel, .busy, .done,
    .intHold, .memReq, .memAddr, .memValid, .memData, .upperAcc,
    .lowerAcc, .flags, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .irq);
  core_mem_model i_mem (.clock, .memReq, .memAddr, .memValid, .memData);

  ////////////////////////////////////////////////////////////////////////
  // verdict and comparison
  task automatic wrap_up;
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // register port and instruction drivers
  task automatic wr(input logic [3:0] a, input logic [17:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [17:0] d);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    @(posedge clock);
    d = regRdata;
  endtask

  task automatic setacc(input logic [17:0] u, input logic [17:0] l);
    wr(arith_pkg::REG_UPPER, u);
    wr(arith_pkg::REG_LOWER, l);
  endtask

  // cyc counts edges from start until done is seen
  task automatic run(input logic [5:0] op, input logic [11:0] a);
    @(posedge clock);
    start <= 1'b1;
    opcode <= op;
    addrField <= a;
    cyc = 0;
    do begin
      @(posedge clock);
      start <= 1'b0;
      cyc++;
    end while (done !== 1'b1 && cyc < 600);
    if (cyc >= 600) begin
      n_fail++;
      wrap_up();
    end
  endtask

  task automatic skip(input logic [5:0] m);
    @(posedge clock);
    start <= 1'b1;
    opcode <= arith_pkg::OP_FORMAT2;
    minorCode <= m;
    @(posedge clock);
    start <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic s_load;
    i_mem.mem[16'h0100] = 18'h2AAAA;
    i_mem.mem[16'h3104] = 18'h15555;
    i_mem.mem[16'hD100] = 18'h0F0F0;
    setacc(18'h3FFFF, 18'h3FFFF);
    run(arith_pkg::OP_LOAD_UPPER, 12'h100);
    chk(upperAcc, 18'h2AAAA);
    chk(36'(cyc), 36'(arith_pkg::SINGLE_CYCLES + 2));
    progBank <= 4'h3;
    indexReg <= 18'h00004;
    run(arith_pkg::OP_LOAD_LOWER + 6'h01, 12'h100);
    chk(lowerAcc, 18'h15555);
    chk({memReq, memAddr}, {1'b0, 16'h3104});
    bankSel <= 5'h1D;
    indexReg <= 18'h00000;
    run(arith_pkg::OP_LOAD_UPPER, 12'h100);
    chk(upperAcc, 18'h0F0F0);
    bankSel <= 5'h00;
    progBank <= 4'h0;
  endtask

  task automatic s_cmp;
    i_mem.mem[16'h0200] = 18'h00003;
    i_mem.mem[16'h0201] = 18'h0A729;
    setacc(18'h00FFF, 18'h00005);
    run(arith_pkg::OP_COMPARE_LOWER, 12'h200);
    chk(flags[2:0], 3'h3);
    chk(lowerAcc, 18'h00005);
    chk(intHold, 1'b1);
    setacc(18'h00FFF, 18'h3FFFC);
    run(arith_pkg::OP_COMPARE_LOWER, 12'h200);
    chk(flags[2:0], 3'h1);
    setacc(18'h00FFF, 18'h124E9);
    run(arith_pkg::OP_COMPARE_MASKED, 12'h201);
    chk(flags[2:0], 3'h1);
    chk({upperAcc, lowerAcc}, {18'h00FFF, 18'h124E9});
    setacc(18'h00FFF, 18'h0A729);
    indexReg <= 18'h00001;
    run(arith_pkg::OP_COMPARE_LOWER + 6'h01, 12'h200);
    chk(flags[2:0], 3'h5);
    indexReg <= 18'h00000;
    run(arith_pkg::OP_LOAD_UPPER, 12'h201);
    chk(intHold, 1'b0);
  endtask

  // substitute under a slow memory answer
  task automatic s_subst;
    i_mem.lat = 30;
    i_mem.mem[16'h0300] = 18'h0A729;
    setacc(18'h00FFF, 18'h36DB6);
    run(arith_pkg::OP_MASKED_SUBSTITUTE, 12'h300);
    chk({upperAcc, lowerAcc}, {18'h00FFF, 18'h36729});
    i_mem.lat = 1;
  endtask

  task automatic s_add;
    i_mem.mem[16'h0400] = 18'h3FFFF;
    i_mem.mem[16'h0401] = 18'h00000;
    i_mem.mem[16'h0402] = 18'h00001;
    i_mem.mem[16'h0403] = 18'h3FFFD;
    setacc(18'h00000, 18'h3FFFF);
    run(arith_pkg::OP_ADD_LOWER, 12'h400);
    chk(lowerAcc, 18'h3FFFF);
    run(arith_pkg::OP_SUB_LOWER, 12'h401);
    chk(lowerAcc, 18'h3FFFF);
    setacc(18'h00000, 18'h00005);
    run(arith_pkg::OP_ADD_LOWER, 12'h403);
    chk(lowerAcc, 18'h00003);
    run(arith_pkg::OP_SUB_LOWER, 12'h403);
    chk(lowerAcc, 18'h00005);
    chk(flags[3], 1'b0);
    setacc(18'h00000, 18'h1FFFF);
    run(arith_pkg::OP_ADD_LOWER, 12'h402);
    chk({lowerAcc, flags[3]}, {18'h20000, 1'b1});
    run(arith_pkg::OP_LOAD_LOWER, 12'h401);
    skip(6'h31);
    chk(flags[3], 1'b1);
    skip(arith_pkg::MINOR_SKIP_OVF);
    chk(flags[3], 1'b0);
    setacc(18'h00000, 18'h20000);
    run(arith_pkg::OP_SUB_LOWER, 12'h402);
    chk({lowerAcc, flags[3]}, {18'h1FFFF, 1'b1});
    skip(arith_pkg::MINOR_SKIP_NO_OVF);
    chk(flags[3], 1'b0);
  endtask

  task automatic s_dbl;
    i_mem.mem[16'h0F46] = 18'h1D253;
    i_mem.mem[16'h0F47] = 18'h07F18;
    setacc(18'h10207, 18'h23065);
    run(arith_pkg::OP_ADD_DOUBLE, 12'hF46);
    chk({upperAcc, lowerAcc}, 36'h6048002B9);
    chk(flags[4:3], 2'h2);
    chk(36'(cyc), 36'(arith_pkg::DOUBLE_CYCLES + 2));
    chk(memAddr, 16'h0F47);
    rd(arith_pkg::REG_FLAGS, rv);
    chk(rv, 18'h00010);
    rd(arith_pkg::REG_LOWER, rv);
    chk(rv, 18'h002B9);
    run(arith_pkg::OP_ADD_LOWER, 12'h401);
    chk(flags[4], 1'b1);
    setacc(18'h18120, 18'h002B9);
    run(arith_pkg::OP_SUB_DOUBLE, 12'hF46);
    chk({upperAcc, lowerAcc}, 36'h4081E3066);
    chk(flags[4:3], 2'h0);
  endtask

  task automatic s_mul;
    i_mem.mem[16'h0500] = 18'h00005;
    i_mem.mem[16'h0501] = 18'h1FFFF;
    setacc(18'h00000, 18'h3FFFC);
    run(arith_pkg::OP_MULTIPLY_LOWER, 12'h500);
    chk({upperAcc, lowerAcc}, 36'hFFFFFFFF0);
    chk(36'(cyc), 36'(arith_pkg::MULTIPLY_CYCLES + 2));
    setacc(18'h00000, 18'h1FFFF);
    run(arith_pkg::OP_MULTIPLY_LOWER, 12'h501);
    chk({upperAcc, lowerAcc}, 36'h3FFFC0001);
  endtask

  // status is sticky until read; mask gates the level interrupt
  task automatic s_irq;
    wr(arith_pkg::REG_MASK, 18'h00000);
    rd(arith_pkg::REG_STATUS, rv);
    run(arith_pkg::OP_LOAD_UPPER, 12'h500);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0);
    rd(arith_pkg::REG_STATUS, rv);
    chk(rv[0], 1'b1);
    rd(arith_pkg::REG_STATUS, rv);
    chk(rv, 18'h00000);
    wr(arith_pkg::REG_MASK, 18'h00001);
    run(arith_pkg::OP_LOAD_UPPER, 12'h500);
    repeat (2) @(posedge clock);
    chk(irq, 1'b1);
    rd(arith_pkg::REG_STATUS, rv);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0);
    rd(4'hF, rv);
    chk(rv, 18'h00000);
  endtask

  initial begin
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    chk({flags, irq, busy}, 7'h00);
    s_load();
    s_cmp();
    s_subst();
    s_add();
    s_dbl();
    s_mul();
    s_irq();
    wrap_up();
  end
endmodule
`default_nettype wire
